/* hw/qfe_unit.sv */
// Quad float execution unit: accumulator, instruction datapath, register port
`default_nettype none
// What this block does
// [RULE_01] Compare-and-skip compares the accumulator with the 112-bit operand: greater skips 0, equal 1, less 2 words.
// [RULE_02] With quad support switched off every quad instruction raises the unimplemented-instruction fault.
// [RULE_03] Divide splits the accumulator by the 112-bit operand, normalises and writes the whole quotient back.
// [RULE_04] Divide flags a float exception on overflow, underflow or a zero divisor.
// [RULE_05] A float exception sets the carry, and also raises the float fault when the keys mask bit is 0.
// [RULE_06] Divide, multiply and subtract clear the carry when they end without exception.
// [RULE_07] Load takes 112 bits and zeroes the rest, or all 128 bits, leaving the carry alone.
// [RULE_08] Load-index shifts the 16-bit operand left three places with zeros in and leaves the flags alone.
// [RULE_09] Multiply forms accumulator times operand, normalised, with overflow or underflow as an exception.
// [RULE_10] Subtract takes the operand from the accumulator, normalised, with overflow or underflow as an exception.
// [RULE_11] Store hands out all 128 accumulator bits unnormalised and leaves the carry alone.
// [RULE_12] The two conversions may raise an exception that leaves the accumulator unchanged, else clear the carry.
// [RULE_13] Rounding with exponent above '200 and below '340 strips the fraction and adds one if its top bit is set.
// [RULE_14] Rounding at exponent '200 gives 0, or -1 for a negative sign with bits 2-96 zero; below it gives 0.
// [RULE_15] One 128-bit accumulator serves all quad instructions and is read and written whole.
module qfe_unit
  import qfe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire qfe_bus_t bus,
  output logic [31:0] bus_rdata,
  input wire logic cmd_valid,
  input wire qfe_cmd_t cmd,
  output logic cmd_ready,
  input wire logic keys_fp_mask,
  output logic rsp_valid,
  output qfe_rsp_t rsp,
  output logic carry_bit,
  output logic irq
);
  typedef enum logic {S_IDLE, S_WAIT} qfe_fsm_t;

  typedef struct packed {
    qfe_fsm_t fsm;
    logic [127:0] acc;
    logic carry;
    logic qen;
    logic ldfull;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic rsp_valid;
    logic rsp_arith;
    logic rsp_conv;
    qfe_rsp_t rsp;
    logic [31:0] rdata;
    logic p_sign;
    logic [18:0] p_exp;
  } qfe_state_t;

  function automatic logic [95:0] qfe_abs(input logic [95:0] v);
    return v[95] ? 96'(~v + 96'h1) : v;
  endfunction

  qfe_state_t st_r;
  qfe_state_t st_nxt;
  logic fire;
  logic sa;
  logic sb;
  logic [95:0] ma;
  logic [95:0] mb;
  logic [15:0] ea;
  logic [15:0] eb;
  logic a_big;
  logic [15:0] ediff;
  logic [95:0] msh_a;
  logic [95:0] msh_b;
  logic [96:0] va;
  logic [96:0] vb;
  logic [96:0] d;
  logic [95:0] dmag;
  logic is_round;
  logic [7:0] nint;
  logic [7:0] kbits;
  logic [95:0] lowmask;
  logic [95:0] cv_mag;
  logic [95:0] nm_in;
  logic [18:0] ne_in;
  logic n_sign;
  logic [94:0] n_mag;
  logic [15:0] n_exp;
  logic n_ovf;
  logic n_unf;
  logic n_zero;
  logic [127:0] packed_res;
  logic itr_start;
  logic itr_done;
  logic [95:0] itr_res;
  logic fin;
  logic exc;
  logic unimplemented_instruction_fault;
  logic wracc;
  logic arith;
  logic conv;
  logic [127:0] newacc;
  logic [IRQ_W-1:0] clr;

  assign cmd_ready = (st_r.fsm == S_IDLE);
  assign fire = cmd_valid && cmd_ready && ce;

  // Operand unpacking: two's-complement fraction turned into sign and magnitude
  assign sa = st_r.acc[SIGN_POS];
  assign sb = cmd.operand[SIGN_POS];
  assign ma = qfe_abs(st_r.acc[SIGN_POS:FRAC_LO]);
  assign mb = qfe_abs(cmd.operand[SIGN_POS:FRAC_LO]);
  assign ea = st_r.acc[EXP_HI:EXP_LO];
  assign eb = cmd.operand[EXP_HI:EXP_LO];

  // Alignment for subtract and compare; both sides drop one bit so the difference cannot overflow
  assign a_big = ea >= eb;
  assign ediff = a_big ? ea - eb : eb - ea;
  assign msh_a = a_big ? {1'b0, ma[95:1]} : ((ediff > 16'h005F) ? 96'h0 : {1'b0, ma[95:1]} >> ediff);
  assign msh_b = !a_big ? {1'b0, mb[95:1]} : ((ediff > 16'h005F) ? 96'h0 : {1'b0, mb[95:1]} >> ediff);
  assign va = sa ? 97'h0 - {1'b0, msh_a} : {1'b0, msh_a};
  assign vb = sb ? 97'h0 - {1'b0, msh_b} : {1'b0, msh_b};
  assign d = va - vb; // RULE_10
  assign dmag = d[96] ? 96'(97'h0 - d) : d[95:0];

  // Conversion: mask off the fraction below the binary point, optionally round up
  assign is_round = (cmd.opword == OPW_ROUND);
  assign nint = (ea > EXP_UNITY) ? 8'(ea - EXP_UNITY) : 8'h00;
  assign kbits = (nint < 8'h5F) ? 8'h5F - nint : 8'h00;
  assign lowmask = (96'h1 << kbits) - 96'h1;
  assign cv_mag = (ma & ~lowmask) + ((is_round && (kbits != 8'h00) && ((ma & (lowmask ^ (lowmask >> 1))) != 96'h0))
                  ? (96'h1 << kbits) : 96'h0); // RULE_13

  // One normaliser is shared: only one instruction is ever in flight
  always_comb begin
    if (st_r.fsm == S_WAIT) begin
      nm_in = itr_res;
      ne_in = st_r.p_exp;
      n_sign = st_r.p_sign;
    end else if (cmd.opword == OPW_TRUNC || is_round) begin
      nm_in = cv_mag;
      ne_in = {3'h0, ea};
      n_sign = sa;
    end else begin
      nm_in = dmag;
      ne_in = {3'h0, a_big ? ea : eb} + 19'h00001;
      n_sign = d[96];
    end
  end

  qfe_norm u_norm (
    .in_mag(nm_in),
    .in_exp(ne_in),
    .out_mag(n_mag),
    .out_exp(n_exp),
    .ovf(n_ovf),
    .unf(n_unf),
    .zero(n_zero)
  );

  assign packed_res = n_zero ? 128'h0 : {(n_sign ? 96'h0 - {1'b0, n_mag} : {1'b0, n_mag}), n_exp, 16'h0000};

  qfe_iter u_iter (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .start(itr_start),
    .div_sel(cmd.opword == OPW_DIV),
    .a_in(ma[94:0]),
    .b_in(mb[94:0]),
    .done(itr_done),
    .res(itr_res)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid = 1'b0;
    st_nxt.rdata = 32'h0000_0000;
    itr_start = 1'b0;
    fin = 1'b0;
    exc = 1'b0;
    unimplemented_instruction_fault = 1'b0;
    wracc = 1'b0;
    arith = 1'b0;
    conv = 1'b0;
    newacc = packed_res;
    clr = '0;
    if (fire) begin
      st_nxt.rsp.skip = 2'h0;
      if (!st_r.qen) begin
        fin = 1'b1;
        unimplemented_instruction_fault = 1'b1; // RULE_02
      end else if (cmd.ldx) begin
        fin = 1'b1;
        st_nxt.rsp.index_data = {cmd.operand[LDX_HI:LDX_LO], 3'h0}; // RULE_08
      end else if (cmd.opword == OPW_LOAD) begin
        fin = 1'b1;
        wracc = 1'b1;
        newacc = st_r.ldfull ? cmd.operand : {cmd.operand[127:16], 16'h0000}; // RULE_07
      end else if (cmd.opword == OPW_STORE) begin
        fin = 1'b1;
        st_nxt.rsp.store_data = st_r.acc; // RULE_11
      end else if (cmd.opword == OPW_CMP) begin
        fin = 1'b1;
        st_nxt.rsp.skip = d[96] ? 2'h2 : ((d == 97'h0) ? 2'h1 : 2'h0); // RULE_01
      end else if (cmd.opword == OPW_SUB) begin
        fin = 1'b1;
        arith = 1'b1;
        wracc = 1'b1;
        exc = n_ovf || n_unf; // RULE_10
      end else if (cmd.opword == OPW_MUL || cmd.opword == OPW_DIV) begin
        arith = 1'b1;
        if (cmd.opword == OPW_DIV && mb == 96'h0) begin
          fin = 1'b1;
          exc = 1'b1; // RULE_04
        end else begin
          itr_start = 1'b1;
          st_nxt.fsm = S_WAIT;
          st_nxt.p_sign = sa ^ sb;
          st_nxt.p_exp = (cmd.opword == OPW_DIV) ? {3'h0, ea} - {3'h0, eb} + EXP_BIAS
                                                   : {3'h0, ea} + {3'h0, eb} - EXP_BIAS; // RULE_09
        end
      end else if (cmd.opword == OPW_TRUNC || is_round) begin
        fin = 1'b1;
        conv = 1'b1;
        wracc = 1'b1;
        exc = ea > EXP_RND_MAX; // RULE_12
        if (ea < EXP_UNITY || (ea == EXP_UNITY && !is_round)) begin
          newacc = 128'h0; // RULE_14
        end else if (ea == EXP_UNITY) begin
          newacc = (sa && st_r.acc[126:FRAC_LO] == 95'h0) ? QACC_NEG_ONE : 128'h0; // RULE_14
        end
      end else begin
        fin = 1'b1;
        unimplemented_instruction_fault = 1'b1;
      end
    end else if (st_r.fsm == S_WAIT && itr_done && ce) begin
      // Quotient or product lands whole in the accumulator unless it overflows or underflows
      fin = 1'b1;
      arith = 1'b1;
      wracc = 1'b1;
      exc = n_ovf || n_unf; // RULE_03
      st_nxt.fsm = S_IDLE;
    end
    if (fin) begin
      st_nxt.rsp_valid = 1'b1;
      st_nxt.rsp_arith = arith;
      st_nxt.rsp_conv = conv;
      st_nxt.rsp.fp_exc = exc;
      st_nxt.rsp.fp_fault = exc && !keys_fp_mask; // RULE_05
      st_nxt.rsp.uii_fault = unimplemented_instruction_fault;
      if (exc) begin
        st_nxt.carry = 1'b1; // RULE_05
      end else if (arith || conv) begin
        st_nxt.carry = 1'b0; // RULE_06
      end
      // An excepting instruction never disturbs the accumulator
      if (wracc && !exc) begin
        st_nxt.acc = newacc; // RULE_15
      end
    end
    if (bus.wr) begin
      if (bus.addr == ADR_CTRL) begin
        st_nxt.qen = bus.wdata[CTRL_QEN];
        st_nxt.ldfull = bus.wdata[CTRL_LDFULL];
      end else if (bus.addr == ADR_IRQ_CLR) begin
        clr = bus.wdata[IRQ_W-1:0];
      end else if (bus.addr == ADR_IRQ_EN) begin
        st_nxt.irq_en = bus.wdata[IRQ_W-1:0];
      end
    end
    if (bus.rd) begin
      if (bus.addr == ADR_CTRL) begin
        st_nxt.rdata = {30'h0, st_r.ldfull, st_r.qen};
      end else if (bus.addr == ADR_STATUS) begin
        st_nxt.rdata = {30'h0, st_r.fsm == S_WAIT, st_r.carry};
      end else if (bus.addr == ADR_IRQ_STAT) begin
        st_nxt.rdata = {29'h0, st_r.irq_stat};
      end else if (bus.addr == ADR_IRQ_EN) begin
        st_nxt.rdata = {29'h0, st_r.irq_en};
      end else if (bus.addr == ADR_ACC0) begin
        st_nxt.rdata = st_r.acc[127:96];
      end else if (bus.addr == ADR_ACC1) begin
        st_nxt.rdata = st_r.acc[95:64];
      end else if (bus.addr == ADR_ACC2) begin
        st_nxt.rdata = st_r.acc[63:32];
      end else if (bus.addr == ADR_ACC3) begin
        st_nxt.rdata = st_r.acc[31:0];
      end
    end
    // A new event beats a clear written in the same cycle
    st_nxt.irq_stat = (st_r.irq_stat & ~clr) | {unimplemented_instruction_fault, exc, fin};
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.qen <= CTRL_RST[CTRL_QEN];
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign bus_rdata = st_r.rdata;
  assign rsp_valid = st_r.rsp_valid;
  assign rsp = st_r.rsp;
  assign carry_bit = st_r.carry;
  assign irq = |(st_r.irq_stat & st_r.irq_en);

  default clocking qfe_cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_cmp_skip_count: assert property (fire && st_r.qen && !cmd.ldx && cmd.opword == OPW_CMP // RULE_01
    |=> rsp_valid && rsp.skip == ($past(d[96]) ? 2'h2 : ($past(d == 97'h0) ? 2'h1 : 2'h0)))
    else $error("compare skip count wrong");
  a_uii_when_off: assert property (fire && !st_r.qen // RULE_02
    |=> rsp_valid && rsp.uii_fault && !rsp.fp_exc && st_r.acc == $past(st_r.acc) && carry_bit == $past(carry_bit))
    else $error("disabled quad instruction not faulted");
  a_div_zero_exc: assert property (fire && st_r.qen && !cmd.ldx && cmd.opword == OPW_DIV && mb == 96'h0 // RULE_04
    |=> rsp_valid && rsp.fp_exc && cmd_ready)
    else $error("zero divisor not excepted");
  a_fault_keys_mask: assert property (rsp_valid && rsp.fp_exc // RULE_05
    |-> carry_bit && (rsp.fp_fault == !$past(keys_fp_mask)))
    else $error("exception carry or fault wrong");
  a_carry_clear_ok: assert property (rsp_valid && (st_r.rsp_arith || st_r.rsp_conv) && !rsp.fp_exc |-> !carry_bit) // RULE_06
    else $error("carry not cleared");
  a_load_low_zero: assert property (fire && st_r.qen && !cmd.ldx && cmd.opword == OPW_LOAD && !st_r.ldfull // RULE_07
    |=> st_r.acc == {$past(cmd.operand[127:16]), 16'h0000} && carry_bit == $past(carry_bit))
    else $error("short load wrong");
  a_ldx_shift: assert property (fire && st_r.qen && cmd.ldx // RULE_08
    |=> rsp.index_data == {$past(cmd.operand[LDX_HI:LDX_LO]), 3'h0} && carry_bit == $past(carry_bit))
    else $error("load index shift wrong");
  a_store_whole: assert property (fire && st_r.qen && !cmd.ldx && cmd.opword == OPW_STORE // RULE_11
    |=> rsp.store_data == $past(st_r.acc) && st_r.acc == $past(st_r.acc) && carry_bit == $past(carry_bit))
    else $error("store data wrong");
  a_conv_exc_keep: assert property (rsp_valid && st_r.rsp_conv && rsp.fp_exc |-> st_r.acc == $past(st_r.acc)) // RULE_12
    else $error("conversion exception altered accumulator");
  a_round_neg_one: assert property (fire && st_r.qen && !cmd.ldx && is_round && ea == EXP_UNITY && sa // RULE_14
    && st_r.acc[126:FRAC_LO] == 95'h0 |=> st_r.acc == QACC_NEG_ONE)
    else $error("round to minus one wrong");
  a_round_small_zero: assert property (fire && st_r.qen && !cmd.ldx && is_round && ea < EXP_UNITY // RULE_14
    |=> st_r.acc == 128'h0 && !carry_bit)
    else $error("small exponent not zero");
endmodule // qfe_unit
`default_nettype wire

/* hw/qfe_pkg.sv */
// Package: constants and carriers of the quad float execution unit
`default_nettype none
package qfe_pkg;
  // Accumulator layout: sign, 95 fraction bits, 16-bit exponent, 16 low bits
  localparam int SIGN_POS = 127;
  localparam int FRAC_LO = 32;
  localparam int EXP_HI = 31;
  localparam int EXP_LO = 16;
  localparam int LDX_HI = 124;
  localparam int LDX_LO = 112;
  localparam logic [18:0] EXP_BIAS = 19'h00080;
  localparam logic [15:0] EXP_UNITY = 16'h0080;
  localparam logic [15:0] EXP_RND_MAX = 16'h00E0;
  localparam logic [127:0] QACC_NEG_ONE = {96'h8000_0000_0000_0000_0000_0000, 16'h0080, 16'h0000};
  // Second opcode words and conversion opcodes
  localparam logic [15:0] OPW_LOAD = 16'h0000;
  localparam logic [15:0] OPW_STORE = 16'h0001;
  localparam logic [15:0] OPW_SUB = 16'h0003;
  localparam logic [15:0] OPW_MUL = 16'h0004;
  localparam logic [15:0] OPW_DIV = 16'h0005;
  localparam logic [15:0] OPW_CMP = 16'h0006;
  localparam logic [15:0] OPW_TRUNC = 16'hC17A;
  localparam logic [15:0] OPW_ROUND = 16'hC17B;
  // Iteration counts of the multiply and divide engine
  localparam logic [6:0] MUL_STEPS = 7'h5F;
  localparam logic [6:0] DIV_STEPS = 7'h60;
  // Register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h0C;
  localparam logic [7:0] ADR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADR_ACC0 = 8'h20;
  localparam logic [7:0] ADR_ACC1 = 8'h24;
  localparam logic [7:0] ADR_ACC2 = 8'h28;
  localparam logic [7:0] ADR_ACC3 = 8'h2C;
  localparam int CTRL_QEN = 0;
  localparam int CTRL_LDFULL = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int IRQ_W = 3;
  localparam int EV_DONE = 0;
  localparam int EV_FPX = 1;
  localparam int EV_UII = 2;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } qfe_bus_t;

  typedef struct packed {
    logic ldx;
    logic [15:0] opword;
    logic [127:0] operand;
  } qfe_cmd_t;

  typedef struct packed {
    logic [1:0] skip;
    logic fp_exc;
    logic fp_fault;
    logic uii_fault;
    logic [15:0] index_data;
    logic [127:0] store_data;
  } qfe_rsp_t;
endpackage
`default_nettype wire

/* hw/qfe_norm.sv */
// Combinational normaliser: magnitude shift, exponent adjust, range check
`default_nettype none
module qfe_norm
  import qfe_pkg::*;
(
  input wire logic [95:0] in_mag,
  input wire logic [18:0] in_exp,
  output logic [94:0] out_mag,
  output logic [15:0] out_exp,
  output logic ovf,
  output logic unf,
  output logic zero
);
  logic [6:0] lz;
  logic [18:0] e;

  always_comb begin
    lz = 7'h00;
    for (int i = 0; i < 95; i++) begin
      if (in_mag[i]) begin
        lz = 7'(94 - i);
      end
    end
    // A carry out of the fraction costs one low bit
    if (in_mag[95]) begin
      out_mag = in_mag[95:1];
      e = in_exp + 19'h00001;
    end else begin
      out_mag = in_mag[94:0] << lz;
      e = in_exp - {12'h000, lz};
    end
    zero = (in_mag == 96'h0);
    out_exp = e[15:0];
    unf = !zero && e[18];
    ovf = !zero && !e[18] && (e[17:16] != 2'h0);
  end
endmodule // qfe_norm
`default_nettype wire

/* hw/qfe_iter.sv */
// Bit-serial engine for fraction multiply and divide
`default_nettype none
module qfe_iter
  import qfe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic start,
  input wire logic div_sel,
  input wire logic [94:0] a_in,
  input wire logic [94:0] b_in,
  output logic done,
  output logic [95:0] res
);
  typedef struct packed {
    logic busy;
    logic div;
    logic done;
    logic [6:0] cnt;
    logic [95:0] rem;
    logic [94:0] b;
    logic [95:0] q;
  } qfe_iter_st_t;

  qfe_iter_st_t st_r;
  qfe_iter_st_t st_nxt;
  logic ge;
  logic [95:0] rsub;
  logic [95:0] sum;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    ge = st_r.rem >= {1'b0, st_r.b};
    rsub = ge ? st_r.rem - {1'b0, st_r.b} : st_r.rem;
    sum = {1'b0, st_r.rem[94:0]} + (st_r.q[0] ? {1'b0, st_r.b} : 96'h0);
    if (start) begin
      st_nxt.busy = 1'b1;
      st_nxt.div = div_sel;
      st_nxt.cnt = div_sel ? DIV_STEPS : MUL_STEPS;
      st_nxt.rem = div_sel ? {1'b0, a_in} : 96'h0;
      st_nxt.b = div_sel ? b_in : a_in;
      st_nxt.q = div_sel ? 96'h0 : {1'b0, b_in};
    end else if (st_r.busy) begin
      if (st_r.div) begin
        // Restoring divide: first quotient bit is the integer bit
        st_nxt.rem = rsub << 1;
        st_nxt.q = {st_r.q[94:0], ge};
      end else begin
        // Shift-add multiply keeps only the upper half of the product
        st_nxt.rem = {1'b0, sum[95:1]};
        st_nxt.q = st_r.q >> 1;
      end
      st_nxt.cnt = st_r.cnt - 7'h01;
      if (st_r.cnt == 7'h01) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
  assign res = st_r.div ? st_r.q : {1'b0, st_r.rem[94:0]};
endmodule // qfe_iter
`default_nettype wire

/* tb/qfe_seq_model.sv */
// Sequencer model: issues instructions and collects responses
`default_nettype none
module qfe_seq_model
  import qfe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire qfe_rsp_t rsp,
  output logic cmd_valid,
  output qfe_cmd_t cmd,
  output logic keys_fp_mask
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    keys_fp_mask = 1'b0;
  end
  // Idle gap of one to three cycles, so the mask line is never driven twice in one step
  task automatic issue(input logic ldx, input logic [15:0] opw, input logic [127:0] opd,
                       input logic mask, output qfe_rsp_t got, output int lat);
    int n;
    n = $urandom_range(2);
    repeat (n + 1) @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd <= '{ldx, opw, opd};
    keys_fp_mask <= mask;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
    cmd_valid <= 1'b0;
    // Released lines show the inverse, never a stale copy
    cmd <= ~cmd;
    lat = 0;
    do begin
      @(posedge sys_clk);
      lat++;
    end while (rsp_valid !== 1'b1 && lat < 200);
    got = rsp;
    keys_fp_mask <= ~mask;
  endtask
endmodule // qfe_seq_model
`default_nettype wire

/* tb/test_quad_float_execution_unit.sv */
// Self-checking bench of the quad float execution unit
`default_nettype none
module test_quad_float_execution_unit
  import qfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk;
  logic nrst;
  logic ce;
  qfe_bus_t bus;
  logic [31:0] bus_rdata;
  logic cmd_valid;
  qfe_cmd_t cmd;
  logic cmd_ready;
  logic keys_fp_mask;
  logic rsp_valid;
  qfe_rsp_t rsp;
  logic carry_bit;
  logic irq;
  int fail_count;
  int comparisons;
  int cycles;
  logic [127:0] m_acc;
  logic m_carry;
  logic m_qen;
  logic m_full;
  logic [31:0] rd;

  qfe_unit uut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .bus(bus), .bus_rdata(bus_rdata),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .keys_fp_mask(keys_fp_mask),
    .rsp_valid(rsp_valid), .rsp(rsp), .carry_bit(carry_bit), .irq(irq));
  qfe_seq_model seq (.sys_clk(sys_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .cmd_valid(cmd_valid), .cmd(cmd), .keys_fp_mask(keys_fp_mask));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic bwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic brd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    @(posedge sys_clk);
    d = bus_rdata;
  endtask

  function automatic logic [127:0] fl(input logic [15:0] f, input logic [15:0] e);
    return {f, 80'h0, e, 16'h0};
  endfunction

  // Reference model: accumulator and carry follow each response
  task automatic run(input logic ldx, input logic [15:0] opw, input logic [127:0] opd, input logic mask,
                     input logic [127:0] res, input logic exc, input int lat_x);
    qfe_rsp_t got;
    int lat;
    logic unimplemented_instruction_fault;
    unimplemented_instruction_fault = !m_qen || (!ldx && !(opw inside {OPW_LOAD, OPW_STORE, OPW_SUB, OPW_MUL, OPW_DIV,
                                           OPW_CMP, OPW_TRUNC, OPW_ROUND}));
    seq.issue(ldx, opw, opd, mask, got, lat);
    check(128'(got.uii_fault), 128'(unimplemented_instruction_fault));
    check(128'(lat), 128'(lat_x));
    if (!unimplemented_instruction_fault && ldx) begin
      check(128'(got.index_data), 128'({opd[124:112], 3'h0}));
    end else if (!unimplemented_instruction_fault && exc) begin
      check(128'(got.fp_exc), 128'h1);
      check(128'(got.fp_fault), 128'(!mask));
      m_carry = 1'b1;
    end else if (!unimplemented_instruction_fault) begin
      check(128'(got.fp_exc), 128'h0);
      case (opw)
        OPW_LOAD: m_acc = m_full ? opd : {opd[127:16], 16'h0};
        OPW_STORE: check(got.store_data, m_acc);
        OPW_CMP: check(128'(got.skip), res);
        default: begin
          m_acc = res;
          m_carry = 1'b0;
        end
      endcase
    end
    check(128'(carry_bit), 128'(m_carry));
  endtask

  task automatic ld(input logic [127:0] v);
    run(1'b0, OPW_LOAD, v, 1'b0, 128'h0, 1'b0, 1);
  endtask

  task automatic st();
    run(1'b0, OPW_STORE, ~m_acc, 1'b0, 128'h0, 1'b0, 1);
  endtask

  logic [127:0] cmp_op [3];
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    bus = '0;
    fail_count = 0;
    comparisons = 0;
    cycles = 0;
    m_acc = '0;
    m_carry = 1'b0;
    m_qen = 1'b1;
    m_full = 1'b0;
    cmp_op = '{fl(16'h4000, 16'h0082), fl(16'h6000, 16'h0081), fl(16'h4000, 16'h0081)};
    void'($urandom(81));
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    check(128'(cmd_ready), 128'h1);
    brd(ADR_CTRL, rd);
    check(128'(rd), 128'h1);
    brd(8'h40, rd);
    check(128'(rd), 128'h0);
    ld({$urandom, $urandom, $urandom, $urandom});
    st();
    bwr(ADR_CTRL, 32'h3);
    m_full = 1'b1;
    ld({$urandom, $urandom, $urandom, $urandom});
    st();
    for (int i = 0; i < 4; i++) begin
      brd(ADR_ACC0 + 8'(4 * i), rd);
      check(128'(rd), 128'(m_acc[127 - 32 * i -: 32]));
    end
    for (int i = 0; i < 4; i++) begin
      run(1'b1, 16'h0, {(i == 0) ? 16'hFFFF : 16'($urandom), 112'h0}, 1'b0, 128'h0, 1'b0, 1);
    end
    bwr(ADR_IRQ_EN, 32'h2);
    ld(fl(16'h6000, 16'h0081));
    run(1'b0, OPW_DIV, 128'h0, 1'b1, 128'h0, 1'b1, 1);
    brd(ADR_STATUS, rd);
    check(128'(rd), 128'h1);
    brd(ADR_IRQ_STAT, rd);
    check(128'(rd[2:1]), 128'h1);
    check(128'(irq), 128'h1);
    bwr(ADR_IRQ_CLR, 32'h7);
    brd(ADR_IRQ_STAT, rd);
    check(128'(irq), 128'h0);
    // Load must not touch the carry left by the exception
    ld(fl(16'h6000, 16'h0081));
    run(1'b0, OPW_SUB, fl(16'h4000, 16'h0081), 1'b0, fl(16'h4000, 16'h0080), 1'b0, 1);
    st();
    ld(fl(16'h6000, 16'h0081));
    run(1'b0, OPW_MUL, fl(16'h4000, 16'h0081), 1'b0, fl(16'h6000, 16'h0081), 1'b0, 97);
    run(1'b0, OPW_DIV, fl(16'h4000, 16'h0081), 1'b0, fl(16'h6000, 16'h0081), 1'b0, 98);
    st();
    for (int i = 0; i < 3; i++) begin
      run(1'b0, OPW_CMP, cmp_op[i], 1'b0, 128'(2 - i), 1'b0, 1);
    end
    run(1'b0, OPW_ROUND, 128'h0, 1'b0, fl(16'h4000, 16'h0082), 1'b0, 1);
    st();
    ld(fl(16'h6000, 16'h0081));
    run(1'b0, OPW_TRUNC, 128'h0, 1'b0, fl(16'h4000, 16'h0081), 1'b0, 1);
    ld(QACC_NEG_ONE);
    run(1'b0, OPW_ROUND, 128'h0, 1'b0, QACC_NEG_ONE, 1'b0, 1);
    ld(fl(16'hA000, 16'h0080));
    run(1'b0, OPW_ROUND, 128'h0, 1'b0, 128'h0, 1'b0, 1);
    ld(fl(16'h4000, 16'h0080));
    run(1'b0, OPW_ROUND, 128'h0, 1'b0, 128'h0, 1'b0, 1);
    ld(fl(16'h4000, 16'h007F));
    run(1'b0, OPW_ROUND, 128'h0, 1'b0, 128'h0, 1'b0, 1);
    // Masked interrupt: status still records the exception
    bwr(ADR_IRQ_EN, 32'h0);
    ld(fl(16'h4000, 16'h00E1));
    run(1'b0, OPW_ROUND, 128'h0, 1'b0, 128'h0, 1'b1, 1);
    run(1'b0, OPW_TRUNC, 128'h0, 1'b1, 128'h0, 1'b1, 1);
    // Exponent out of range on subtract and multiply leaves the accumulator alone
    ld(fl(16'h6000, 16'h0000));
    run(1'b0, OPW_SUB, fl(16'h4000, 16'h0000), 1'b0, 128'h0, 1'b1, 1);
    ld(fl(16'h4000, 16'hC000));
    run(1'b0, OPW_MUL, fl(16'h4000, 16'hC000), 1'b1, 128'h0, 1'b1, 97);
    st();
    brd(ADR_IRQ_STAT, rd);
    check(128'({rd[1], irq}), 128'h2);
    bwr(ADR_IRQ_EN, 32'h4);
    run(1'b0, 16'h0007, 128'h0, 1'b0, 128'h0, 1'b0, 1);
    // A write while the clock enable is low is lost
    ce <= 1'b0;
    bwr(ADR_CTRL, 32'h0);
    ce <= 1'b1;
    brd(ADR_CTRL, rd);
    check(128'(rd), 128'h3);
    bwr(ADR_CTRL, 32'h0);
    m_qen = 1'b0;
    run(1'b0, OPW_STORE, 128'h0, 1'b0, 128'h0, 1'b0, 1);
    run(1'b1, 16'h0, 128'h0, 1'b0, 128'h0, 1'b0, 1);
    brd(ADR_IRQ_STAT, rd);
    check(128'({rd[2], irq}), 128'h3);
    close_out();
  end
endmodule // test_quad_float_execution_unit
`default_nettype wire
